// file: pcd_pump_detector_ctrl_regs.sv
`timescale 1ns/1ps
`default_nettype none

module pcd_pump_detector_ctrl_regs (
  input wire logic clk_i,
  input wire logic rst_i,
  // byte access from the serial-port engine, same clock
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  output logic reg_hit_o,
  // settings chosen by the automatic loop logic, same clock
  input wire logic [7:0] auto_pump_current_i,
  input wire logic [1:0] auto_pump_mode_i,
  input wire logic [1:0] auto_backlash_i,
  input wire logic auto_offset_direction_i,
  input wire logic [7:0] auto_offset_current_i,
  // effective controls toward the analog core
  output logic [7:0] pump_current_o,
  output logic [1:0] pump_operating_mode_o,
  output logic pump_offset_direction_o,
  output logic [7:0] pump_offset_current_o,
  output logic [1:0] backlash_period_o,
  output logic feedback_edge_fall_o,
  output logic reference_edge_fall_o,
  output logic vco_midscale_o,
  output logic lock_detect_pd_o,
  output logic commit_pulse_o
);

  // scaled offset current: code shifted right by magnitude plus one
  function automatic logic [7:0] offset_scale(input logic [7:0] code, input logic [1:0] mag);
    logic [7:0] res;
    res = 8'h00;
    case (mag)
      2'b00: res = code >> 1;
      2'b01: res = code >> 2;
      2'b10: res = code >> 3;
      default: res = code >> 4;
    endcase
    return res;
  endfunction

  // true when an address belongs to the buffered group
  function automatic logic is_buffered(input logic [7:0] addr);
    return (addr == pcd_pkg::ADDR_PUMP_CURRENT_CODE) ||
           (addr == pcd_pkg::ADDR_PUMP_MODE_AND_EDGES) ||
           (addr == pcd_pkg::ADDR_PUMP_OFFSET_CONTROL) ||
           (addr == pcd_pkg::ADDR_BACKLASH_AND_LOCK_POWER);
  endfunction

  // readback source for a buffered register
  function automatic logic [7:0] readback_pick(input logic sel, input logic [7:0] pending,
    input logic [7:0] applied);
    return sel ? pending : applied;
  endfunction

  // a write strobe aimed at one address
  function automatic logic write_hits(input logic wr, input logic [7:0] addr, input logic [7:0] target);
    return wr && (addr == target);
  endfunction

  logic [7:0] buf_current_reg;
  logic [7:0] buf_mode_reg;
  logic [7:0] buf_offset_reg;
  logic [7:0] buf_backlash_reg;
  logic [7:0] act_current_reg;
  logic [7:0] act_mode_reg;
  logic [7:0] act_offset_reg;
  logic [7:0] act_backlash_reg;
  logic readback_sel_reg;
  logic commit_next;
  logic [7:0] rdata_next;
  logic hit_next;
  logic wr_readback_sel;
  logic wr_current;
  logic wr_mode;
  logic wr_offset;
  logic wr_backlash;
  logic current_ovr;
  logic backlash_ovr;
  logic mode_ovr;
  logic offset_ovr;
  logic [1:0] prog_mode;
  logic [1:0] prog_backlash;
  logic [1:0] prog_magnitude;

  assign commit_next = write_hits(reg_wr_i, reg_addr_i, pcd_pkg::ADDR_COMMIT) && reg_wdata_i[pcd_pkg::COMMIT_BIT];

  // one write enable per register keeps the buffer blocks apart
  assign wr_readback_sel = write_hits(reg_wr_i, reg_addr_i, pcd_pkg::ADDR_READBACK_SEL);
  assign wr_current = write_hits(reg_wr_i, reg_addr_i, pcd_pkg::ADDR_PUMP_CURRENT_CODE);
  assign wr_mode = write_hits(reg_wr_i, reg_addr_i, pcd_pkg::ADDR_PUMP_MODE_AND_EDGES);
  assign wr_offset = write_hits(reg_wr_i, reg_addr_i, pcd_pkg::ADDR_PUMP_OFFSET_CONTROL);
  assign wr_backlash = write_hits(reg_wr_i, reg_addr_i, pcd_pkg::ADDR_BACKLASH_AND_LOCK_POWER);

  // override enables and programmed fields come from the active copy only
  assign current_ovr = act_mode_reg[pcd_pkg::MODE_CURRENT_OVR_BIT];
  assign backlash_ovr = act_mode_reg[pcd_pkg::MODE_BACKLASH_OVR_BIT];
  assign mode_ovr = act_mode_reg[pcd_pkg::MODE_PUMP_MODE_OVR_BIT];
  assign offset_ovr = act_offset_reg[pcd_pkg::OFFS_OVR_BIT];
  assign prog_mode = act_mode_reg[pcd_pkg::MODE_PUMP_MODE_LSB +: 2];
  assign prog_backlash = act_backlash_reg[pcd_pkg::BKL_PERIOD_LSB +: 2];
  assign prog_magnitude = act_offset_reg[pcd_pkg::OFFS_MAGNITUDE_LSB +: 2];

  // buffer registers take every write; reserved bits are dropped here
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      buf_current_reg <= pcd_pkg::RST_PUMP_CURRENT_CODE;
    end else if (wr_current) begin
      buf_current_reg <= reg_wdata_i & pcd_pkg::MASK_PUMP_CURRENT_CODE;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      buf_mode_reg <= pcd_pkg::RST_PUMP_MODE_AND_EDGES;
    end else if (wr_mode) begin
      buf_mode_reg <= reg_wdata_i & pcd_pkg::MASK_PUMP_MODE_AND_EDGES;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      buf_offset_reg <= pcd_pkg::RST_PUMP_OFFSET_CONTROL;
    end else if (wr_offset) begin
      buf_offset_reg <= reg_wdata_i & pcd_pkg::MASK_PUMP_OFFSET_CONTROL;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      buf_backlash_reg <= pcd_pkg::RST_BACKLASH_AND_LOCK_POWER;
    end else if (wr_backlash) begin
      buf_backlash_reg <= reg_wdata_i & pcd_pkg::MASK_BACKLASH_AND_LOCK_POWER;
    end
  end

  // active registers change only on a commit
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      act_current_reg <= pcd_pkg::RST_PUMP_CURRENT_CODE;
    end else if (commit_next) begin
      act_current_reg <= buf_current_reg;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      act_mode_reg <= pcd_pkg::RST_PUMP_MODE_AND_EDGES;
    end else if (commit_next) begin
      act_mode_reg <= buf_mode_reg;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      act_offset_reg <= pcd_pkg::RST_PUMP_OFFSET_CONTROL;
    end else if (commit_next) begin
      act_offset_reg <= buf_offset_reg;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      act_backlash_reg <= pcd_pkg::RST_BACKLASH_AND_LOCK_POWER;
    end else if (commit_next) begin
      act_backlash_reg <= buf_backlash_reg;
    end
  end

  // readback select is not buffered
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      readback_sel_reg <= pcd_pkg::RST_READBACK_SEL;
    end else if (wr_readback_sel) begin
      readback_sel_reg <= reg_wdata_i[pcd_pkg::READBACK_SEL_BIT];
    end
  end

  // commit is self-clearing: a one-cycle pulse, never stored
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      commit_pulse_o <= 1'b0;
    end else begin
      commit_pulse_o <= commit_next;
    end
  end

  // read decode; unmapped addresses return zero
  always_comb begin
    rdata_next = 8'h00;
    if (reg_addr_i == pcd_pkg::ADDR_READBACK_SEL) begin
      rdata_next = {7'h00, readback_sel_reg};
    end else if (reg_addr_i == pcd_pkg::ADDR_COMMIT) begin
      rdata_next = 8'h00;
    end else if (reg_addr_i == pcd_pkg::ADDR_PUMP_CURRENT_CODE) begin
      rdata_next = readback_pick(readback_sel_reg, buf_current_reg, act_current_reg);
    end else if (reg_addr_i == pcd_pkg::ADDR_PUMP_MODE_AND_EDGES) begin
      rdata_next = readback_pick(readback_sel_reg, buf_mode_reg, act_mode_reg);
    end else if (reg_addr_i == pcd_pkg::ADDR_PUMP_OFFSET_CONTROL) begin
      rdata_next = readback_pick(readback_sel_reg, buf_offset_reg, act_offset_reg);
    end else if (reg_addr_i == pcd_pkg::ADDR_BACKLASH_AND_LOCK_POWER) begin
      rdata_next = readback_pick(readback_sel_reg, buf_backlash_reg, act_backlash_reg);
    end
  end

  assign hit_next = is_buffered(reg_addr_i) || (reg_addr_i == pcd_pkg::ADDR_READBACK_SEL) ||
    (reg_addr_i == pcd_pkg::ADDR_COMMIT);

  // read strobe answered exactly one cycle later
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
    end
  end

  // read data and hit flag hold until the next read
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rdata_next;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_hit_o <= 1'b0;
    end else if (reg_rd_i) begin
      reg_hit_o <= hit_next;
    end
  end

  // pump current: programmed code only under override
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pump_current_o <= pcd_pkg::RST_PUMP_CURRENT_CODE;
    end else if (current_ovr) begin
      pump_current_o <= act_current_reg;
    end else begin
      pump_current_o <= auto_pump_current_i;
    end
  end

  // pump operating mode
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pump_operating_mode_o <= pcd_pkg::PCD_MODE_NORMAL;
    end else if (mode_ovr) begin
      pump_operating_mode_o <= prog_mode;
    end else begin
      pump_operating_mode_o <= auto_pump_mode_i;
    end
  end

  // antibacklash period
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      backlash_period_o <= pcd_pkg::PCD_BKL_MINIMUM;
    end else if (backlash_ovr) begin
      backlash_period_o <= prog_backlash;
    end else begin
      backlash_period_o <= auto_backlash_i;
    end
  end

  // offset direction under override, automatic otherwise
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pump_offset_direction_o <= 1'b0;
    end else if (offset_ovr) begin
      pump_offset_direction_o <= act_offset_reg[pcd_pkg::OFFS_DIRECTION_BIT];
    end else begin
      pump_offset_direction_o <= auto_offset_direction_i;
    end
  end

  // offset current: fraction of the active programmed code under override
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pump_offset_current_o <= 8'h00;
    end else if (offset_ovr) begin
      pump_offset_current_o <= offset_scale(act_current_reg, prog_magnitude);
    end else begin
      pump_offset_current_o <= auto_offset_current_i;
    end
  end

  // edge selects, midscale force and lock detector power-down act directly
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      feedback_edge_fall_o <= 1'b0;
    end else begin
      feedback_edge_fall_o <= act_mode_reg[pcd_pkg::MODE_FEEDBACK_FALL_BIT];
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      reference_edge_fall_o <= 1'b0;
    end else begin
      reference_edge_fall_o <= act_mode_reg[pcd_pkg::MODE_REFERENCE_FALL_BIT];
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      vco_midscale_o <= 1'b0;
    end else begin
      vco_midscale_o <= act_mode_reg[pcd_pkg::MODE_VCO_MIDSCALE_BIT];
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      lock_detect_pd_o <= 1'b0;
    end else begin
      lock_detect_pd_o <= act_backlash_reg[pcd_pkg::BKL_LOCK_PD_BIT];
    end
  end

endmodule

`default_nettype wire

// file: pcd_pkg.sv
`default_nettype none
package pcd_pkg;

  // register addresses on the serial-port register space
  localparam logic [7:0] ADDR_READBACK_SEL = 8'h04;
  localparam logic [7:0] ADDR_COMMIT = 8'h05;
  localparam logic [7:0] ADDR_PUMP_CURRENT_CODE = 8'h0a;
  localparam logic [7:0] ADDR_PUMP_MODE_AND_EDGES = 8'h0b;
  localparam logic [7:0] ADDR_PUMP_OFFSET_CONTROL = 8'h0c;
  localparam logic [7:0] ADDR_BACKLASH_AND_LOCK_POWER = 8'h0d;

  // values after reset
  localparam logic [7:0] RST_PUMP_CURRENT_CODE = 8'h80;
  localparam logic [7:0] RST_PUMP_MODE_AND_EDGES = 8'h30;
  localparam logic [7:0] RST_PUMP_OFFSET_CONTROL = 8'h00;
  localparam logic [7:0] RST_BACKLASH_AND_LOCK_POWER = 8'h00;
  localparam logic RST_READBACK_SEL = 1'b0;

  // bits that hold state; everything else reads zero
  localparam logic [7:0] MASK_PUMP_CURRENT_CODE = 8'hff;
  localparam logic [7:0] MASK_PUMP_MODE_AND_EDGES = 8'hff;
  localparam logic [7:0] MASK_PUMP_OFFSET_CONTROL = 8'h78;
  localparam logic [7:0] MASK_BACKLASH_AND_LOCK_POWER = 8'hc1;

  // pump_mode_and_edges fields
  localparam int MODE_CURRENT_OVR_BIT = 7;
  localparam int MODE_BACKLASH_OVR_BIT = 6;
  localparam int MODE_PUMP_MODE_LSB = 4;
  localparam int MODE_PUMP_MODE_OVR_BIT = 3;
  localparam int MODE_FEEDBACK_FALL_BIT = 2;
  localparam int MODE_REFERENCE_FALL_BIT = 1;
  localparam int MODE_VCO_MIDSCALE_BIT = 0;

  // pump_offset_control fields
  localparam int OFFS_DIRECTION_BIT = 6;
  localparam int OFFS_MAGNITUDE_LSB = 4;
  localparam int OFFS_OVR_BIT = 3;

  // backlash_and_lock_power fields
  localparam int BKL_PERIOD_LSB = 6;
  localparam int BKL_LOCK_PD_BIT = 0;

  // commit and readback-select bits
  localparam int COMMIT_BIT = 0;
  localparam int READBACK_SEL_BIT = 0;

  typedef enum logic [1:0] {
    PCD_MODE_TRISTATE = 2'b00,
    PCD_MODE_PUMP_UP = 2'b01,
    PCD_MODE_PUMP_DOWN = 2'b10,
    PCD_MODE_NORMAL = 2'b11
  } pcd_pump_mode_type;

  typedef enum logic [1:0] {
    PCD_BKL_MINIMUM = 2'b00,
    PCD_BKL_LOW = 2'b01,
    PCD_BKL_HIGH = 2'b10,
    PCD_BKL_MAXIMUM = 2'b11
  } pcd_backlash_type;

endpackage

`default_nettype wire

// file: pcd_regs_sva.sv
`timescale 1ns/1ps
`default_nettype none
module pcd_regs_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic reg_rvalid_o,
  input wire logic reg_hit_o,
  input wire logic [7:0] auto_pump_current_i,
  input wire logic [1:0] auto_pump_mode_i,
  input wire logic [7:0] pump_current_o,
  input wire logic [1:0] pump_operating_mode_o,
  input wire logic feedback_edge_fall_o,
  input wire logic reference_edge_fall_o,
  input wire logic vco_midscale_o,
  input wire logic lock_detect_pd_o,
  input wire logic commit_pulse_o
);
  logic cm;
  assign cm = reg_wr_i && reg_addr_i == 8'h05 && reg_wdata_i[0];
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_RVALID: assert property (reg_rd_i |=> reg_rvalid_o) else $error("read valid missing");
  AST_PULSE: assert property (cm |=> commit_pulse_o) else $error("commit pulse missing");
  AST_PCAUSE: assert property (commit_pulse_o |-> $past(cm)) else $error("commit pulse unprompted");
  AST_EDGES: assert property (
    $changed({feedback_edge_fall_o, reference_edge_fall_o, vco_midscale_o, lock_detect_pd_o})
    |-> $past(commit_pulse_o)) else $error("flag changed without commit");
  AST_MODE: assert property (
    $changed(pump_operating_mode_o) && !$past(rst_i, 2) |-> $past(commit_pulse_o)
    || $past(auto_pump_mode_i) != $past(auto_pump_mode_i, 2)) else $error("pump mode changed without cause");
  AST_CUR: assert property (
    $changed(pump_current_o) && !$past(rst_i, 2) |-> $past(commit_pulse_o)
    || $past(auto_pump_current_i) != $past(auto_pump_current_i, 2)) else $error("current changed without cause");
  AST_UNMAP: assert property (
    reg_rd_i && reg_addr_i == 8'h20 |=> !reg_hit_o && reg_rdata_o == 8'h00) else $error("unmapped read wrong");
  AST_RSVD: assert property (
    reg_rd_i && reg_addr_i == 8'h0c |=> reg_hit_o && reg_rdata_o[2:0] == 3'h0 && !reg_rdata_o[7])
    else $error("reserved bits not zero");
endmodule
bind pcd_pump_detector_ctrl_regs pcd_regs_chk u_chk (.clk_i, .rst_i, .reg_wr_i, .reg_rd_i, .reg_addr_i,
  .reg_wdata_i, .reg_rdata_o, .reg_rvalid_o, .reg_hit_o, .auto_pump_current_i, .auto_pump_mode_i,
  .pump_current_o, .pump_operating_mode_o, .feedback_edge_fall_o, .reference_edge_fall_o, .vco_midscale_o,
  .lock_detect_pd_o, .commit_pulse_o);
`default_nettype wire

// file: tb_pcd.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_i = 1'b0, rst_i = 1'b1, wr = 1'b0, rd = 1'b0, ad = 1'b1;
  logic [7:0] addr = 8'h00, wd = 8'h00, ac = 8'h3c, ao = 8'h11;
  logic [1:0] am = 2'b01, ab = 2'b10;
  logic [7:0] rdat, pc, poc;
  logic [1:0] pm, bk;
  logic rv, hit, pd, fb, rf, mid, lpd, cmt;
  int failures = 0;
  int n_compared = 0;
  always #5 clk_i = ~clk_i;
  pcd_pump_detector_ctrl_regs DUT (.clk_i(clk_i), .rst_i(rst_i), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_addr_i(addr), .reg_wdata_i(wd), .reg_rdata_o(rdat), .reg_rvalid_o(rv), .reg_hit_o(hit),
    .auto_pump_current_i(ac), .auto_pump_mode_i(am), .auto_backlash_i(ab), .auto_offset_direction_i(ad),
    .auto_offset_current_i(ao), .pump_current_o(pc), .pump_operating_mode_o(pm), .pump_offset_direction_o(pd),
    .pump_offset_current_o(poc), .backlash_period_o(bk), .feedback_edge_fall_o(fb),
    .reference_edge_fall_o(rf), .vco_midscale_o(mid), .lock_detect_pd_o(lpd), .commit_pulse_o(cmt));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr <= 1'b1;
    addr <= a;
    wd <= d;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [7:0] e, input logic h);
    @(posedge clk_i);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_i);
    rd <= 1'b0;
    #1;
    chk("rvalid_hit", {6'h00, 1'b1, h}, {6'h00, rv, hit});
    chk("rdata", e, rdat);
  endtask
  // outputs move two edges after the commit write
  task automatic commit;
    wreg(8'h05, 8'h01);
    #1;
    chk("commit", 8'h01, {7'h00, cmt});
    repeat (2) @(posedge clk_i);
    #1;
    chk("commit", 8'h00, {7'h00, cmt});
  endtask
  task automatic t_reset;
    rreg(8'h0a, 8'h80, 1'b1);
    rreg(8'h0b, 8'h30, 1'b1);
    rreg(8'h0c, 8'h00, 1'b1);
    rreg(8'h0d, 8'h00, 1'b1);
    rreg(8'h04, 8'h00, 1'b1);
    chk("cur", ac, pc);
    chk("mode", {6'h00, am}, {6'h00, pm});
    chk("bkl", {6'h00, ab}, {6'h00, bk});
    chk("odir", {7'h00, ad}, {7'h00, pd});
    chk("ocur", ao, poc);
    chk("flags", 8'h00, {4'h0, fb, rf, mid, lpd});
    @(posedge clk_i);
    ac <= 8'hc3;
    am <= 2'b10;
    repeat (2) @(posedge clk_i);
    #1;
    chk("cur", 8'hc3, pc);
    chk("mode", 8'h02, {6'h00, pm});
  endtask
  task automatic t_buffer;
    wreg(8'h0a, 8'h5c);
    wreg(8'h0b, 8'h87);
    rreg(8'h0a, 8'h80, 1'b1);
    wreg(8'h04, 8'hff);
    rreg(8'h0a, 8'h5c, 1'b1);
    rreg(8'h04, 8'h01, 1'b1);
    wreg(8'h05, 8'hfe);
    #1;
    chk("commit", 8'h00, {7'h00, cmt});
    repeat (2) @(posedge clk_i);
    #1;
    chk("cur", ac, pc);
    commit();
    chk("cur", 8'h5c, pc);
    chk("mode", {6'h00, am}, {6'h00, pm});
    chk("flags", 8'h0e, {4'h0, fb, rf, mid, lpd});
    wreg(8'h04, 8'h00);
    rreg(8'h0b, 8'h87, 1'b1);
    rreg(8'h05, 8'h00, 1'b1);
  endtask
  task automatic t_modes;
    for (int m = 0; m < 4; m++) begin
      wreg(8'h0b, {2'b00, m[1:0], 4'h8});
      commit();
      chk("mode", {6'h00, m[1:0]}, {6'h00, pm});
      chk("cur", ac, pc);
    end
  endtask
  task automatic t_offset;
    wreg(8'h0a, 8'hf0);
    for (int k = 0; k < 4; k++) begin
      wreg(8'h0c, {2'b11, k[1:0], 4'hf});
      commit();
      chk("odir", 8'h01, {7'h00, pd});
      chk("ocur", 8'(8'hf0 >> (k + 1)), poc);
      rreg(8'h0c, {2'b01, k[1:0], 4'h8}, 1'b1);
    end
    wreg(8'h0c, 8'h08);
    commit();
    chk("odir", 8'h00, {7'h00, pd});
    wreg(8'h0c, 8'h70);
    commit();
    chk("ocur", ao, poc);
  endtask
  task automatic t_bkl;
    wreg(8'h0b, 8'h40);
    for (int b = 0; b < 4; b++) begin
      wreg(8'h0d, {b[1:0], 6'h3f});
      commit();
      chk("bkl", {6'h00, b[1:0]}, {6'h00, bk});
      chk("lpd", 8'h01, {7'h00, lpd});
      rreg(8'h0d, {b[1:0], 6'h01}, 1'b1);
    end
    wreg(8'h0b, 8'h00);
    commit();
    chk("bkl", {6'h00, ab}, {6'h00, bk});
    wreg(8'h20, 8'hff);
    rreg(8'h20, 8'h00, 1'b0);
  endtask
  task automatic summarize;
    if (failures == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_buffer();
    t_modes();
    t_offset();
    t_bkl();
    summarize();
  end
  initial begin
    #20000;
    failures++;
    summarize();
  end
endmodule
`default_nettype wire
